// File: rtl/dlx_defs.svh
`ifndef DLX_DEFS_SVH
`define DLX_DEFS_SVH
`define DLX_PREFIX_BYTE     8'hfe
`define DLX_OP_WDIV_HI      6'h23
`define DLX_OP_BDIV_HI      6'h27
`define DLX_OP_LOOP_BYTE    8'he0
`define DLX_OP_LOOP_WORD    8'he1
`define DLX_DIV_STEPS_W     6'h20
`define DLX_DIV_STEPS_B     6'h10
`endif

// File: rtl/dlx_pkg.sv
package dlx_pkg;
  typedef enum logic [2:0] {
    DLX_OP_NONE,
    DLX_OP_SWDIV,
    DLX_OP_SBDIV,
    DLX_OP_UWDIV,
    DLX_OP_UBDIV,
    DLX_OP_LOOPB,
    DLX_OP_LOOPW
  } dlx_op_type;
endpackage : dlx_pkg

// File: rtl/dlx_divider.sv
`timescale 1ns/100ps
`default_nettype none
`include "dlx_defs.svh"
// ****************************************
// unsigned restoring divider, one bit per cycle
// ****************************************
module dlx_divider (
  input  wire logic        i_clk,
  input  wire logic        i_rst,
  input  wire logic        i_start,
  input  wire logic        i_wide,
  input  wire logic [31:0] i_dividend,
  input  wire logic [15:0] i_divisor,
  output logic             o_done,
  output logic [31:0]      o_quot,
  output logic [15:0]      o_rem
);
  logic [5:0]  cnt_q;
  logic [31:0] quot_q;
  logic [16:0] rem_q;
  logic [16:0] trial;
  logic [16:0] shifted;
  logic        busy_q;

  assign shifted = {rem_q[15:0], quot_q[31]};
  assign trial   = shifted - {1'b0, i_divisor};

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      busy_q <= 1'b0;
      cnt_q  <= 6'h00;
      quot_q <= 32'h0000_0000;
      rem_q  <= 17'h0_0000;
      o_done <= 1'b0;
    end else begin
      o_done <= 1'b0;
      if (i_start) begin
        busy_q <= 1'b1;
        cnt_q  <= i_wide ? `DLX_DIV_STEPS_W : `DLX_DIV_STEPS_B;
        quot_q <= i_wide ? i_dividend : {i_dividend[15:0], 16'h0000};
        rem_q  <= 17'h0_0000;
      end else if (busy_q) begin
        // only the divisor is read here; the caller holds it for the whole run, while dividend and i_wide are read at start only
        if (!trial[16]) begin
          rem_q  <= trial;
          quot_q <= {quot_q[30:0], 1'b1};
        end else begin
          rem_q  <= shifted;
          quot_q <= {quot_q[30:0], 1'b0};
        end
        cnt_q <= cnt_q - 6'h01;
        if (cnt_q == 6'h01) begin
          busy_q <= 1'b0;
          o_done <= 1'b1;
        end
      end
    end
  end

  assign o_quot = quot_q;
  assign o_rem  = rem_q[15:0];
endmodule : dlx_divider
`default_nettype wire

// File: rtl/dlx_exec.sv
`timescale 1ns/100ps
`default_nettype none
`include "dlx_defs.svh"
module dlx_exec
  import dlx_pkg::*;
(
  input  wire logic        i_clk,
  input  wire logic        i_rst,
  input  wire logic        i_start,
  input  wire logic        i_prefix,
  input  wire logic [7:0]  i_opcode,
  input  wire logic [31:0] i_dest,
  input  wire logic [15:0] i_src,
  input  wire logic [7:0]  i_disp,
  input  wire logic [15:0] i_next_pc,
  input  wire logic        i_sticky_in,
  output logic             o_busy,
  output logic             o_done,
  output logic             o_wr_en,
  output logic [31:0]      o_wr_data,
  output logic             o_wr_wide,
  output logic             o_pc_load,
  output logic [15:0]      o_pc,
  output logic             o_ovf_wr,
  output logic             o_ovf,
  output logic             o_sticky_excess_flag
);
  // ****************************************
  // decode
  // ****************************************
  dlx_op_type op_d;
  always_comb begin
    op_d = DLX_OP_NONE;
    if (i_opcode[7:2] == `DLX_OP_WDIV_HI)
      op_d = i_prefix ? DLX_OP_SWDIV : DLX_OP_UWDIV;
    else if (i_opcode[7:2] == `DLX_OP_BDIV_HI)
      op_d = i_prefix ? DLX_OP_SBDIV : DLX_OP_UBDIV;
    else if (!i_prefix && i_opcode == `DLX_OP_LOOP_BYTE)
      op_d = DLX_OP_LOOPB;
    else if (!i_prefix && i_opcode == `DLX_OP_LOOP_WORD)
      op_d = DLX_OP_LOOPW;
  end

  // ****************************************
  // operand capture and sign handling
  // ****************************************
  typedef enum logic [1:0] {ST_IDLE, ST_DIV, ST_FIN} dlx_st_type;
  dlx_st_type  st_q;
  dlx_op_type  op_q;
  logic        wide_q, sgn_q, neg_q_q, neg_r_q;
  logic [31:0] mag_dvd_q;
  logic [15:0] mag_dvs_q;
  logic [31:0] abs_dvd;
  logic [15:0] abs_dvs;
  logic        dvd_neg, dvs_neg, is_div, is_wide, is_sgn;
  logic        div_done;
  logic [31:0] uq;
  logic [15:0] ur;

  assign is_div  = (op_d inside {DLX_OP_SWDIV, DLX_OP_SBDIV,
                                 DLX_OP_UWDIV, DLX_OP_UBDIV});
  assign is_wide = (op_d == DLX_OP_SWDIV) || (op_d == DLX_OP_UWDIV);
  assign is_sgn  = (op_d == DLX_OP_SWDIV) || (op_d == DLX_OP_SBDIV);
  assign dvd_neg = is_sgn && (is_wide ? i_dest[31] : i_dest[15]);
  assign dvs_neg = is_sgn && (is_wide ? i_src[15] : i_src[7]);

  always_comb begin
    if (is_wide)
      abs_dvd = dvd_neg ? 32'h0 - i_dest : i_dest;
    else
      abs_dvd = {16'h0000, dvd_neg ? 16'h0 - i_dest[15:0] : i_dest[15:0]};
    if (is_wide)
      abs_dvs = dvs_neg ? 16'h0 - i_src : i_src;
    else
      abs_dvs = {8'h00, dvs_neg ? 8'h0 - i_src[7:0] : i_src[7:0]};
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      op_q      <= DLX_OP_NONE;
      wide_q    <= 1'b0;
      sgn_q     <= 1'b0;
      neg_q_q   <= 1'b0;
      neg_r_q   <= 1'b0;
      mag_dvd_q <= 32'h0000_0000;
      mag_dvs_q <= 16'h0000;
    end else if (st_q == ST_IDLE && i_start) begin
      op_q      <= op_d;
      wide_q    <= is_wide;
      sgn_q     <= is_sgn;
      neg_q_q   <= dvd_neg ^ dvs_neg;
      neg_r_q   <= dvd_neg;
      mag_dvd_q <= abs_dvd;
      mag_dvs_q <= abs_dvs;
    end
  end

  // divisor is read on every step, so it comes from the latched copy:
  // the decoder inputs may move on once the divide is taken
  dlx_divider u_div (
    .i_clk      (i_clk),
    .i_rst      (i_rst),
    .i_start    (st_q == ST_IDLE && i_start && is_div),
    .i_wide     (is_wide),
    .i_dividend (abs_dvd),
    .i_divisor  (mag_dvs_q),
    .o_done     (div_done),
    .o_quot     (uq),
    .o_rem      (ur)
  );

  // ****************************************
  // result shaping and overflow
  // ****************************************
  logic [31:0] sq;
  logic [15:0] sr;
  logic        ovf;
  assign sq = neg_q_q ? 32'h0 - uq : uq;
  assign sr = neg_r_q ? 16'h0 - ur : ur;

  always_comb begin
    // zero divisor counts as overflow
    ovf = (mag_dvs_q == 16'h0000);
    if (wide_q && sgn_q)
      ovf = ovf || (uq[31:16] != 16'h0)
            || (uq[15] && !(neg_q_q && uq[14:0] == 15'h0));
    else if (wide_q)
      ovf = ovf || (uq[31:16] != 16'h0);
    else if (sgn_q)
      ovf = ovf || (uq[15:8] != 8'h0)
            || (uq[7] && !(neg_q_q && uq[6:0] == 7'h0));
    else
      ovf = ovf || (uq[15:8] != 8'h0);
  end

  // ****************************************
  // loop decrement and branch target
  // ****************************************
  logic [15:0] cnt_dec;
  logic [15:0] tgt;
  logic        cnt_zero;
  assign cnt_dec  = i_dest[15:0] - 16'h0001;
  assign cnt_zero = (op_d == DLX_OP_LOOPB) ? (cnt_dec[7:0] == 8'h00)
                                           : (cnt_dec == 16'h0000);
  assign tgt = i_next_pc + {{8{i_disp[7]}}, i_disp};

  // ****************************************
  // sequencing and outputs
  // ****************************************
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      st_q      <= ST_IDLE;
      o_busy    <= 1'b0;
      o_done    <= 1'b0;
      o_wr_en   <= 1'b0;
      o_wr_data <= 32'h0000_0000;
      o_wr_wide <= 1'b0;
      o_pc_load <= 1'b0;
      o_pc      <= 16'h0000;
      o_ovf_wr  <= 1'b0;
      o_ovf     <= 1'b0;
      o_sticky_excess_flag <= 1'b0;
    end else begin
      o_done    <= 1'b0;
      o_wr_en   <= 1'b0;
      o_pc_load <= 1'b0;
      o_ovf_wr  <= 1'b0;
      unique case (st_q)
        ST_IDLE: begin
          if (i_start && is_div) begin
            st_q   <= ST_DIV;
            o_busy <= 1'b1;
          end else if (i_start && (op_d == DLX_OP_LOOPB
                                   || op_d == DLX_OP_LOOPW)) begin
            o_done    <= 1'b1;
            o_wr_en   <= 1'b1;
            o_wr_wide <= (op_d == DLX_OP_LOOPW);
            o_wr_data <= (op_d == DLX_OP_LOOPB)
                         ? {i_dest[31:8], cnt_dec[7:0]}
                         : {i_dest[31:16], cnt_dec};
            o_pc_load <= !cnt_zero;
            o_pc      <= cnt_zero ? i_next_pc : tgt;
          end
        end
        ST_DIV: begin
          if (div_done)
            st_q <= ST_FIN;
        end
        ST_FIN: begin
          st_q      <= ST_IDLE;
          o_busy    <= 1'b0;
          o_done    <= 1'b1;
          o_wr_en   <= 1'b1;
          o_wr_wide <= wide_q;
          o_wr_data <= wide_q ? {sr, sq[15:0]}
                              : {16'h0000, sr[7:0], sq[7:0]};
          o_ovf_wr  <= 1'b1;
          o_ovf     <= ovf;
          o_sticky_excess_flag <= i_sticky_in | ovf;
        end
        default: st_q <= ST_IDLE;
      endcase
    end
  end

  // ****************************************
  // checks
  // ****************************************
  sequence div_issue_s;
    st_q == ST_IDLE && i_start && is_div;
  endsequence
  sequence div_commit_s;
    o_wr_en && o_ovf_wr && o_done;
  endsequence

  div_latency_a: assert property (@(posedge i_clk) disable iff (i_rst)
    div_issue_s |-> ##[3:36] div_commit_s) else $error("divide never committed");
  loop_target_a: assert property (@(posedge i_clk) disable iff (i_rst)
    (st_q == ST_IDLE && i_start && op_d == DLX_OP_LOOPW && !cnt_zero)
    |=> o_pc_load && o_pc == $past(i_next_pc)
        + {{8{$past(i_disp[7])}}, $past(i_disp)}) else $error("bad loop target");
  loop_fall_a: assert property (@(posedge i_clk) disable iff (i_rst)
    (st_q == ST_IDLE && i_start && op_d == DLX_OP_LOOPB
     && i_dest[7:0] == 8'h01) |=> !o_pc_load && o_wr_data[7:0] == 8'h00)
    else $error("byte loop branched at zero");
  loop_word_a: assert property (@(posedge i_clk) disable iff (i_rst)
    (st_q == ST_IDLE && i_start && op_d == DLX_OP_LOOPW)
    |=> o_wr_data[15:0] == $past(i_dest[15:0]) - 16'h0001)
    else $error("word loop decrement wrong");
  sticky_keep_a: assert property (@(posedge i_clk) disable iff (i_rst)
    o_ovf_wr |-> (o_sticky_excess_flag == ($past(i_sticky_in) | o_ovf)))
    else $error("sticky flag not set-only");
  sdiv_decode_a: assert property (@(posedge i_clk) disable iff (i_rst)
    (st_q == ST_IDLE && i_start && i_prefix
     && i_opcode[7:2] == `DLX_OP_WDIV_HI) |=> o_busy && sgn_q && wide_q)
    else $error("signed long divide not decoded");
  sbdiv_decode_a: assert property (@(posedge i_clk) disable iff (i_rst)
    (st_q == ST_IDLE && i_start && i_prefix
     && i_opcode[7:2] == `DLX_OP_BDIV_HI) |=> o_busy && sgn_q && !wide_q)
    else $error("signed short divide not decoded");
  byte_high_a: assert property (@(posedge i_clk) disable iff (i_rst)
    (o_ovf_wr && !o_wr_wide) |-> o_wr_data[31:16] == 16'h0000)
    else $error("byte divide wrote upper word");
endmodule : dlx_exec
`default_nettype wire

// File: testbench/test_divide_and_loop_branch_exec.sv
`timescale 1ns/100ps
`default_nettype none
`include "dlx_defs.svh"
module test_divide_and_loop_branch_exec;
  // ********************************
  // stimulus and observed signals
  // ********************************
  logic        i_clk;
  logic        i_rst;
  logic        i_start;
  logic        i_prefix;
  logic        i_sticky_in;
  logic [7:0]  i_opcode;
  logic [7:0]  i_disp;
  logic [31:0] i_dest;
  logic [15:0] i_src;
  logic [15:0] i_next_pc;
  logic        o_busy;
  logic        o_done;
  logic        o_wr_en;
  logic        o_wr_wide;
  logic        o_pc_load;
  logic        o_ovf_wr;
  logic        o_ovf;
  logic        o_sticky_excess_flag;
  logic [31:0] o_wr_data;
  logic [15:0] o_pc;
  int          err_count;
  int          n_tests;
  int          cycles;
  logic        seen_busy;
  logic        got;
  dlx_exec DUT (.i_clk(i_clk), .i_rst(i_rst), .i_start(i_start),
    .i_prefix(i_prefix), .i_opcode(i_opcode), .i_dest(i_dest),
    .i_src(i_src), .i_disp(i_disp), .i_next_pc(i_next_pc),
    .i_sticky_in(i_sticky_in), .o_busy(o_busy), .o_done(o_done),
    .o_wr_en(o_wr_en), .o_wr_data(o_wr_data), .o_wr_wide(o_wr_wide),
    .o_pc_load(o_pc_load), .o_pc(o_pc), .o_ovf_wr(o_ovf_wr),
    .o_ovf(o_ovf), .o_sticky_excess_flag(o_sticky_excess_flag));
  // ********************************
  // shared tasks
  // ********************************
  task automatic conclude;
    $display("checks %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : conclude
  task automatic chk(input string nm, input logic [31:0] seen,
                     input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      err_count++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  // intrude: a second start while busy, which must be ignored
  task automatic run_op(input logic pre, input logic [7:0] op,
    input logic [31:0] dst, input logic [15:0] src, input logic [7:0] dsp,
    input logic [15:0] npc, input logic stk, input bit intrude);
    @(posedge i_clk);
    i_start     <= 1'b1;
    i_prefix    <= pre;
    i_opcode    <= op;
    i_dest      <= dst;
    i_src       <= src;
    i_disp      <= dsp;
    i_next_pc   <= npc;
    i_sticky_in <= stk;
    @(posedge i_clk);
    i_start   <= 1'b0;
    seen_busy = 1'b0;
    got       = 1'b0;
    for (int n = 0; n < 45 && !got; n++) begin
      #1;
      if (o_busy === 1'b1) seen_busy = 1'b1;
      if (o_done === 1'b1) got = 1'b1;
      else begin
        @(posedge i_clk);
        i_start  <= intrude && n == 1;
        i_opcode <= (intrude && n == 1) ? `DLX_OP_LOOP_BYTE : op;
      end
    end
    chk("done", got, 1'b1);
  endtask : run_op
  // ********************************
  // divide scenarios
  // ********************************
  task automatic div_check(input logic pre, input logic wide,
    input logic [31:0] dst, input logic [15:0] src, input logic stk,
    input bit intrude);
    longint      a;
    longint      b;
    longint      q;
    longint      r;
    logic        ov;
    logic [31:0] ed;
    if (wide && pre) begin
      a = $signed(dst);
      b = $signed(src);
    end else if (wide) begin
      a = dst;
      b = src;
    end else if (pre) begin
      a = $signed(dst[15:0]);
      b = $signed(src[7:0]);
    end else begin
      a = dst[15:0];
      b = src[7:0];
    end
    q = (b != 0) ? a / b : 0;
    r = (b != 0) ? a % b : 0;
    if (b == 0) ov = 1'b1;
    else if (wide) ov = pre ? (q > 32767 || q < -32768) : (q > 65535);
    else ov = pre ? (q > 127 || q < -128) : (q > 255);
    ed = wide ? {r[15:0], q[15:0]} : {16'h0000, r[7:0], q[7:0]};
    run_op(pre, wide ? {`DLX_OP_WDIV_HI, 2'h2} : {`DLX_OP_BDIV_HI, 2'h1},
           dst, src, 8'h00, 16'h0000, stk, intrude);
    chk("busy", seen_busy, 1'b1);
    chk("wr_en", o_wr_en, 1'b1);
    chk("wr_wide", o_wr_wide, wide);
    chk("busy_end", o_busy, 1'b0);
    if (!ov) chk("quot_rem", o_wr_data, ed);
    chk("pc_load", o_pc_load, 1'b0);
    chk("ovf_wr", o_ovf_wr, 1'b1);
    chk("ovf", o_ovf, ov);
    chk("sticky", o_sticky_excess_flag, stk | ov);
  endtask : div_check
  // ********************************
  // loop scenarios
  // ********************************
  task automatic loop_check(input logic word, input logic [31:0] dst,
    input logic [7:0] dsp, input logic [15:0] npc);
    logic [15:0] c16;
    logic [7:0]  c8;
    logic        nz;
    c16 = dst[15:0] - 16'h0001;
    c8  = dst[7:0] - 8'h01;
    nz  = word ? (c16 != 16'h0000) : (c8 != 8'h00);
    run_op(1'b0, word ? `DLX_OP_LOOP_WORD : `DLX_OP_LOOP_BYTE, dst,
           16'h0000, dsp, npc, 1'b0, 0);
    chk("loop_wr_en", o_wr_en, 1'b1);
    chk("loop_wide", o_wr_wide, word);
    chk("loop_ovf_wr", o_ovf_wr, 1'b0);
    chk("loop_data", o_wr_data,
        word ? {dst[31:16], c16} : {dst[31:8], c8});
    chk("pc_load", o_pc_load, nz);
    chk("pc", o_pc,
        nz ? 16'(npc + {{8{dsp[7]}}, dsp}) : npc);
  endtask : loop_check
  // ********************************
  // reset in the middle of a divide
  // ********************************
  task automatic reset_check;
    @(posedge i_clk);
    i_start  <= 1'b1;
    i_prefix <= 1'b0;
    i_opcode <= {`DLX_OP_WDIV_HI, 2'h0};
    i_dest   <= 32'h0000_0064;
    i_src    <= 16'h0005;
    @(posedge i_clk);
    i_start <= 1'b0;
    #1;
    chk("run_busy", o_busy, 1'b1);
    @(posedge i_clk);
    i_rst <= 1'b1;
    repeat (2) @(posedge i_clk);
    #1;
    chk("rst_busy", o_busy, 1'b0);
    chk("rst_wr_en", o_wr_en, 1'b0);
    chk("rst_wr_data", o_wr_data, 32'h0000_0000);
    chk("rst_pc", o_pc, 16'h0000);
    @(posedge i_clk);
    i_rst <= 1'b0;
  endtask : reset_check
  // ********************************
  // clock, reset, sequence, timeout
  // ********************************
  initial begin
    i_clk = 1'b0;
    forever #2 i_clk = ~i_clk;
  end
  always @(posedge i_clk) begin
    cycles++;
    if (cycles == 4000) begin
      err_count++;
      conclude();
    end
  end
  initial begin
    {i_rst, i_start, i_prefix, i_sticky_in} = 4'h8;
    {i_opcode, i_disp, i_dest, i_src, i_next_pc} = '0;
    repeat (2) @(posedge i_clk);
    i_rst <= 1'b0;
    div_check(1'b0, 1'b1, 32'h0001_2345, 16'h0100, 1'b0, 1);
    div_check(1'b0, 1'b1, 32'h0010_0000, 16'h0002, 1'b0, 0);
    div_check(1'b0, 1'b1, 32'hfffe_0001, 16'hffff, 1'b1, 0);
    div_check(1'b0, 1'b1, 32'h1234_5678, 16'h0000, 1'b0, 0);
    div_check(1'b1, 1'b1, 32'hffff_fc18, 16'h0007, 1'b0, 0);
    div_check(1'b1, 1'b1, 32'h0000_8000, 16'h0001, 1'b0, 0);
    div_check(1'b1, 1'b1, 32'h0001_0005, 16'hfffd, 1'b1, 0);
    div_check(1'b0, 1'b0, 32'h0000_1234, 16'h0056, 1'b0, 0);
    div_check(1'b0, 1'b0, 32'h0000_1234, 16'h0010, 1'b0, 0);
    div_check(1'b1, 1'b0, 32'h0000_ff9c, 16'h0007, 1'b0, 1);
    div_check(1'b1, 1'b0, 32'h0000_0080, 16'h00ff, 1'b1, 0);
    reset_check();
    loop_check(1'b0, 32'h1234_5601, 8'h7f, 16'h1000);
    loop_check(1'b0, 32'h0000_0100, 8'h80, 16'h1000);
    loop_check(1'b1, 32'habcd_0100, 8'hfe, 16'h0002);
    loop_check(1'b1, 32'h0000_0001, 8'h10, 16'hfff0);
    loop_check(1'b1, 32'h0000_0000, 8'h7f, 16'hff90);
    conclude();
  end
endmodule : test_divide_and_loop_branch_exec
`default_nettype wire
